/* npor_pkg.sv */
// shared constants and types for the oscillator output stage and registers
package npor_pkg;
    localparam int SUM_W = 20;
    localparam int NUM_SRC = 10;
    localparam int WIDTH_SEL_W = 3;
    localparam int CNT_W = 7;
    //////////////////////////////////////////////////////////////////////
    // register byte addresses on the bus
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_CLOCK = 8'h04;
    localparam logic [7:0] OFF_SUM_LOW = 8'h08;
    localparam logic [7:0] OFF_SUM_HIGH = 8'h0C;
    localparam logic [7:0] OFF_SUM_UPPER = 8'h10;
    localparam logic [7:0] OFF_STEP_LOW = 8'h14;
    localparam logic [7:0] OFF_STEP_HIGH = 8'h18;
    localparam logic [7:0] OFF_STEP_UPPER = 8'h1C;
    localparam logic [7:0] OFF_IRQ = 8'h20;
    //////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_OUT_BIT = 5;
    localparam int CTL_INV_BIT = 4;
    localparam int CTL_PULSED_BIT = 0;
    localparam int CLK_WIDTH_LSB = 5;
    localparam int CLK_SRC_LSB = 0;
    localparam int IRQ_FLAG_BIT = 0;
    localparam int IRQ_EN_BIT = 1;
    //////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CLK_RESET = 8'h00;
    localparam logic [SUM_W-1:0] SUM_RESET = 20'h0_0000;
    localparam logic [SUM_W-1:0] STEP_RESET = 20'h0_0001;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    //////////////////////////////////////////////////////////////////////
    // source select codes
    localparam logic [3:0] SRC_SYSTEM = 4'h0;
    localparam logic [3:0] SRC_FAST_OSC = 4'h1;
    localparam logic [3:0] SRC_LAST = 4'hA;
    //////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        NPOR_IDLE = 2'b00,
        NPOR_ARMED = 2'b01,
        NPOR_ACTIVE = 2'b10
    } npor_pulse_state_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } npor_tick_t;
endpackage

/* npor_accum.sv */
// phase accumulator with double-buffered step value
module npor_accum (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // source clock edges and mode
    input npor_pkg::npor_tick_t tick_i,
    input wire logic enable_i,
    // register side
    input wire logic [npor_pkg::SUM_W-1:0] step_i,
    input wire logic step_low_wr_i,
    input wire logic step_any_wr_i,
    input wire logic [2:0] sum_wr_i,
    input wire logic [7:0] wdata_i,
    // results
    output logic [npor_pkg::SUM_W-1:0] phase_sum_o,
    output logic overflow_event_o
);
    import npor_pkg::*;

    logic [SUM_W-1:0] step_shadow_r;
    logic pend_r;
    logic [SUM_W:0] sum_full;
    wire add_en = tick_i.rise & enable_i;
    // disabled: load right away; enabled: wait for a falling source edge
    wire load_now = pend_r & (~enable_i | tick_i.fall);
    wire pend_set = step_low_wr_i | (~enable_i & step_any_wr_i);

    assign sum_full = {1'b0, phase_sum_o} + {1'b0, step_shadow_r};

    //////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_r <= 1'b0;
            step_shadow_r <= STEP_RESET;
        end else begin
            pend_r <= pend_set | (pend_r & ~load_now);
            if (load_now) begin
                step_shadow_r <= step_i;
            end
        end
    end

    // a bus write beats an add; only legal while stopped anyway
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase_sum_o <= SUM_RESET;
            overflow_event_o <= 1'b0;
        end else begin
            overflow_event_o <= add_en & sum_full[SUM_W];
            if (sum_wr_i[0]) begin
                phase_sum_o[7:0] <= wdata_i;
            end else if (sum_wr_i[1]) begin
                phase_sum_o[15:8] <= wdata_i;
            end else if (sum_wr_i[2]) begin
                phase_sum_o[19:16] <= wdata_i[3:0];
            end else if (add_en) begin
                phase_sum_o <= sum_full[SUM_W-1:0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    chk_add_carry: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        add_en && sum_wr_i == 3'b000
        |=> overflow_event_o == $past(sum_full[SUM_W])
        && phase_sum_o == $past(sum_full[SUM_W-1:0]))
        else $error("accumulator add or carry wrong");
    chk_stopped_hold: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !enable_i && sum_wr_i == 3'b000
        |=> $stable(phase_sum_o) && !overflow_event_o)
        else $error("accumulator moved while stopped");
    chk_shadow_load: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        step_low_wr_i && enable_i ##1 (!tick_i.fall && enable_i)
        |=> $stable(step_shadow_r))
        else $error("step shadow loaded before falling edge");
    chk_stopped_load: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        step_any_wr_i && !enable_i ##1 !enable_i
        |=> step_shadow_r == $past(step_i))
        else $error("step shadow not loaded while stopped");
endmodule

/* npor_top.sv */
// oscillator output stage, register file and bus slave
//
// Contract
// - pulsed mode: active for selected width, then inactive
// - pulse starts at next source rising edge
// - control bit 0: pulsed mode, else toggle
// - width field gives 2^n source periods
// - width field ignored in toggle mode
// - control bit 4 inverts the output
// - polarity change with irq enabled raises irq
// - control bit 5 reads current output level
// - every overflow sets the irq flag
// - irq needs enable, irq enable, global enable
// - flag stays set until software clears it
// - reset zeroes registers, step low resets to 1
// - runs from selected source, also during sleep
// - enabled with fast osc: keep it requested
// - clock register bits 3-0 select source
// - control bit 7 enables the module
// - accumulator in three bytes, upper 4 bits
// - step low write loads shadow at falling edge
// - add step each rising edge, carry is overflow
// - toggle mode flips output on every overflow
// - stopped: step writes load shadow at once
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
module npor_top (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // clock sources, codes 1 to 10, sampled on clk_sys_i
    input wire logic [npor_pkg::NUM_SRC-1:0] src_levels_i,
    // system interrupt context
    input wire logic global_irq_enable_i,
    // outputs
    output logic synth_out_o,
    output logic irq_o,
    output logic fast_osc_request_o
);
    import npor_pkg::*;

    //////////////////////////////////////////////////////////////////////
    // registers
    logic enable_r;
    logic output_invert_r;
    logic pulsed_mode_select_r;
    logic [WIDTH_SEL_W-1:0] pulse_width_select_r;
    logic [3:0] source_clock_select_r;
    logic [SUM_W-1:0] step_r;
    logic overflow_irq_flag_r;
    logic overflow_irq_enable_r;
    logic wait_r;
    logic src_prev_r;
    logic toggle_r;
    logic [CNT_W-1:0] width_cnt_r;
    logic [CNT_W-1:0] width_cnt_nxt;
    npor_pulse_state_t state_r;
    npor_pulse_state_t state_nxt;
    logic [SUM_W-1:0] phase_sum;
    logic overflow_event;
    npor_tick_t tick;
    logic [31:0] rd_mux;
    logic [7:0] rd_byte;

    //////////////////////////////////////////////////////////////////////
    // bus decode: request seen with wait high, answered one cycle later
    wire bus_req = avs_read_i | avs_write_i;
    wire bus_ack = bus_req & ~wait_r;
    wire wr_ok = avs_write_i & bus_ack & avs_byteenable_i[0];
    wire [7:0] wd = avs_writedata_i[7:0];
    wire wr_ctl = wr_ok & (avs_address_i == OFF_CONTROL);
    wire wr_clk = wr_ok & (avs_address_i == OFF_CLOCK);
    wire wr_sum_l = wr_ok & (avs_address_i == OFF_SUM_LOW);
    wire wr_sum_h = wr_ok & (avs_address_i == OFF_SUM_HIGH);
    wire wr_sum_u = wr_ok & (avs_address_i == OFF_SUM_UPPER);
    wire wr_step_l = wr_ok & (avs_address_i == OFF_STEP_LOW);
    wire wr_step_h = wr_ok & (avs_address_i == OFF_STEP_HIGH);
    wire wr_step_u = wr_ok & (avs_address_i == OFF_STEP_UPPER);
    wire wr_irq = wr_ok & (avs_address_i == OFF_IRQ);
    wire step_any_wr = wr_step_l | wr_step_h | wr_step_u;

    //////////////////////////////////////////////////////////////////////
    // source edge detection; code 0 ticks every system cycle
    wire src_valid = (source_clock_select_r != SRC_SYSTEM)
        && (source_clock_select_r <= SRC_LAST);
    wire [3:0] src_idx = source_clock_select_r - 4'h1;
    wire src_level = src_valid & src_levels_i[src_idx];
    wire src_sys = (source_clock_select_r == SRC_SYSTEM);
    // reserved codes give no edges, so the module simply stalls
    assign tick.rise = src_sys | (src_level & ~src_prev_r);
    assign tick.fall = src_sys | (~src_level & src_prev_r);

    //////////////////////////////////////////////////////////////////////
    // pulse stretcher and toggle
    wire run_rise = enable_r & tick.rise;
    wire [CNT_W-1:0] width_load =
        CNT_W'((8'h01 << pulse_width_select_r) - 8'h01);
    wire pulse_raw = (state_r == NPOR_ACTIVE);
    wire out_raw = pulsed_mode_select_r ? pulse_raw : toggle_r;
    wire out_nxt = out_raw ^ output_invert_r;
    wire invert_flip = wr_ctl & (wd[CTL_INV_BIT] != output_invert_r);
    wire flag_set = overflow_event
        | (invert_flip & overflow_irq_enable_r);
    wire flag_clr = wr_irq & ~wd[IRQ_FLAG_BIT];

    always_comb begin
        state_nxt = state_r;
        width_cnt_nxt = width_cnt_r;
        if (overflow_event) begin
            state_nxt = NPOR_ARMED;
        end else if (run_rise) begin
            case (state_r)
                NPOR_ARMED: begin
                    state_nxt = NPOR_ACTIVE;
                    width_cnt_nxt = width_load;
                end
                NPOR_ACTIVE: begin
                    if (width_cnt_r == '0) begin
                        state_nxt = NPOR_IDLE;
                    end else begin
                        width_cnt_nxt = width_cnt_r - CNT_W'(1);
                    end
                end
                default: begin
                    state_nxt = NPOR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= NPOR_IDLE;
            width_cnt_r <= '0;
            toggle_r <= 1'b0;
            src_prev_r <= 1'b0;
            synth_out_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            width_cnt_r <= width_cnt_nxt;
            src_prev_r <= src_level;
            if (overflow_event) begin
                toggle_r <= ~toggle_r;
            end
            synth_out_o <= out_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // accumulator core
    npor_accum u_accum (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .tick_i(tick),
        .enable_i(enable_r),
        .step_i(step_r),
        .step_low_wr_i(wr_step_l),
        .step_any_wr_i(step_any_wr),
        .sum_wr_i({wr_sum_u, wr_sum_h, wr_sum_l}),
        .wdata_i(wd),
        .phase_sum_o(phase_sum),
        .overflow_event_o(overflow_event)
    );

    //////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enable_r <= CTL_RESET[CTL_EN_BIT];
            output_invert_r <= CTL_RESET[CTL_INV_BIT];
            pulsed_mode_select_r <= CTL_RESET[CTL_PULSED_BIT];
            pulse_width_select_r <= CLK_RESET[7:5];
            source_clock_select_r <= CLK_RESET[3:0];
            step_r <= STEP_RESET;
            overflow_irq_flag_r <= 1'b0;
            overflow_irq_enable_r <= 1'b0;
        end else begin
            if (wr_ctl) begin
                enable_r <= wd[CTL_EN_BIT];
                output_invert_r <= wd[CTL_INV_BIT];
                pulsed_mode_select_r <= wd[CTL_PULSED_BIT];
            end
            if (wr_clk) begin
                pulse_width_select_r <= wd[CLK_WIDTH_LSB +: WIDTH_SEL_W];
                source_clock_select_r <= wd[CLK_SRC_LSB +: 4];
            end
            if (wr_step_l) begin
                step_r[7:0] <= wd;
            end
            if (wr_step_h) begin
                step_r[15:8] <= wd;
            end
            if (wr_step_u) begin
                step_r[19:16] <= wd[3:0];
            end
            // set wins over a clear in the same cycle
            overflow_irq_flag_r <= flag_set
                | (overflow_irq_flag_r & ~flag_clr);
            if (wr_irq) begin
                overflow_irq_enable_r <= wd[IRQ_EN_BIT];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // read mux, unmapped addresses read zero
    always_comb begin
        case (avs_address_i)
            OFF_CONTROL: rd_byte = {enable_r, 1'b0, synth_out_o,
                output_invert_r, 3'b000, pulsed_mode_select_r};
            OFF_CLOCK: rd_byte = {pulse_width_select_r, 1'b0,
                source_clock_select_r};
            OFF_SUM_LOW: rd_byte = phase_sum[7:0];
            OFF_SUM_HIGH: rd_byte = phase_sum[15:8];
            OFF_SUM_UPPER: rd_byte = {4'h0, phase_sum[19:16]};
            OFF_STEP_LOW: rd_byte = step_r[7:0];
            OFF_STEP_HIGH: rd_byte = step_r[15:8];
            OFF_STEP_UPPER: rd_byte = {4'h0, step_r[19:16]};
            OFF_IRQ: rd_byte = {6'b00_0000, overflow_irq_enable_r,
                overflow_irq_flag_r};
            default: rd_byte = 8'h00;
        endcase
    end
    assign rd_mux = {24'h00_0000, rd_byte};

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_r <= 1'b1;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= RDATA_RESET;
            irq_o <= 1'b0;
            fast_osc_request_o <= 1'b0;
        end else begin
            wait_r <= bus_ack | ~bus_req;
            avs_waitrequest_o <= bus_ack | ~bus_req;
            if (avs_read_i & wait_r) begin
                avs_readdata_o <= rd_mux;
            end
            irq_o <= enable_r & overflow_irq_enable_r
                & global_irq_enable_i & overflow_irq_flag_r;
            fast_osc_request_o <= enable_r
                & (source_clock_select_r == SRC_FAST_OSC);
        end
    end

    //////////////////////////////////////////////////////////////////////
    chk_pulse_start: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        state_r == NPOR_ARMED && run_rise && !overflow_event
        |=> state_r == NPOR_ACTIVE && width_cnt_r == $past(width_load))
        else $error("pulse did not start on rising edge");

    chk_pulse_end: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        state_r == NPOR_ACTIVE && width_cnt_r == '0 && run_rise
        && !overflow_event |=> state_r == NPOR_IDLE)
        else $error("pulse did not end after width");

    chk_width_span: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(state_r == NPOR_ACTIVE) |-> width_cnt_r ==
        CNT_W'((8'h01 << $past(pulse_width_select_r)) - 8'h01))
        else $error("pulse width count wrong");

    chk_toggle_flip: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        overflow_event |=> toggle_r != $past(toggle_r))
        else $error("toggle did not flip on overflow");

    chk_out_level: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        1'b1 |=> synth_out_o == ($past(out_raw) ^ $past(output_invert_r)))
        else $error("output level or inversion wrong");

    chk_mode_select: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !pulsed_mode_select_r |-> out_raw == toggle_r)
        else $error("width applied in toggle mode");

    chk_flag_sticky: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        overflow_irq_flag_r && !wr_irq |=> overflow_irq_flag_r)
        else $error("flag cleared without software");

    chk_flag_set: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        overflow_event |=> overflow_irq_flag_r)
        else $error("overflow did not set flag");

    chk_pol_irq: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        invert_flip && overflow_irq_enable_r |=> overflow_irq_flag_r)
        else $error("polarity change gave no irq");

    chk_irq_gate: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        irq_o |-> $past(enable_r) && $past(overflow_irq_enable_r)
        && $past(global_irq_enable_i) && $past(overflow_irq_flag_r))
        else $error("irq without all enables");

    chk_level_view: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        avs_read_i && wait_r && avs_address_i == OFF_CONTROL
        |=> avs_readdata_o[CTL_OUT_BIT] == $past(synth_out_o))
        else $error("level view does not match output");

    chk_fast_req: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        enable_r && source_clock_select_r == SRC_FAST_OSC
        |=> fast_osc_request_o)
        else $error("fast oscillator not requested");

    // the answer is a single cycle, so a held request is not taken in two cycles in a row
    chk_wait_pulse: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than a cycle");

    chk_upper_zero: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        avs_read_i && wait_r && avs_address_i == OFF_SUM_UPPER
        |=> avs_readdata_o[7:4] == 4'h0)
        else $error("accumulator upper bits not zero");

    chk_upper_write: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        wr_sum_u |=> phase_sum[19:16] == $past(wd[3:0]))
        else $error("accumulator upper byte write lost");

    chk_reserved_stall: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        source_clock_select_r > SRC_LAST |-> !tick.rise && !tick.fall)
        else $error("reserved source code gave edges");

    chk_toggle_hold: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !overflow_event |=> toggle_r == $past(toggle_r))
        else $error("toggle moved without overflow");

    chk_fast_idle: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !enable_r |=> !fast_osc_request_o)
        else $error("fast oscillator requested while off");
endmodule

/* npor_sink_model.sv */
// consumer model of the synthesized output: measures completed runs
module npor_sink_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // observed output of the block
    input wire logic level_i,
    // lengths of the last completed high and low runs, in system cycles
    output int high_len_o,
    output int low_len_o
);
    int run_r;
    logic last_r;
    //////////////////////////////////////////////////////////////////////
    // only completed runs are reported; the first run is counted from reset and shows once the level first changes
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_r <= 0;
            last_r <= 1'b0;
            high_len_o <= 0;
            low_len_o <= 0;
        end else if (level_i === last_r) begin
            run_r <= run_r + 1;
        end else begin
            if (last_r) begin
                high_len_o <= run_r;
            end else begin
                low_len_o <= run_r;
            end
            run_r <= 1;
            last_r <= level_i;
        end
    end
endmodule

/* npor_top_test.sv */
// self-checking bench for the oscillator output stage and registers
module npor_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import npor_pkg::*;
    logic clk_sys_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [7:0] avs_address_i, q, sv;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0] avs_byteenable_i;
    logic [NUM_SRC-1:0] src_levels_i;
    logic global_irq_enable_i, synth_out_o, irq_o, fast_osc_request_o;
    logic slow_run;
    logic [2:0] div;
    int high_len, low_len, n_fail, cmp_count, w;
    logic [7:0] offs [10] = '{OFF_CONTROL, OFF_CLOCK, OFF_SUM_LOW,
        OFF_SUM_HIGH, OFF_SUM_UPPER, OFF_STEP_LOW, OFF_STEP_HIGH,
        OFF_STEP_UPPER, OFF_IRQ, 8'h24};
    //////////////////////////////////////////////////////////////////////
    npor_top npor_top_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .src_levels_i(src_levels_i),
        .global_irq_enable_i(global_irq_enable_i),
        .synth_out_o(synth_out_o), .irq_o(irq_o),
        .fast_osc_request_o(fast_osc_request_o));
    npor_sink_model npor_sink_model_i (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .level_i(synth_out_o),
        .high_len_o(high_len), .low_len_o(low_len));
    //////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // slow source for select code 2: period of 8 system cycles
    always @(posedge clk_sys_i) begin
        div <= div + 3'h1;
        src_levels_i <= slow_run ? {8'h00, div[2], 1'b0} : '0;
    end
    //////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", s, e, g);
            n_fail++;
        end
    endtask
    task automatic chkw(input string s, input int e, input int g);
        cmp_count++;
        if (g != e) begin
            $display("wrong value %s expected %0d seen %0d", s, e, g);
            n_fail++;
        end
    endtask
    // the request stands until waitrequest is sampled low, never less
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        avs_writedata_i <= {24'h00_0000, d};
        // only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o[7:0];
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string s, input logic [7:0] a,
                       input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(s, e, q);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_fail++;
        close_out();
    end
    initial begin
        {resetn_i, avs_read_i, avs_write_i, slow_run} = 4'h0;
        {avs_address_i, avs_writedata_i, div} = '0;
        src_levels_i = '0;
        avs_byteenable_i = 4'h1;
        global_irq_enable_i = 1'b1;
        n_fail = 0;
        cmp_count = 0;
        wait_n(8);
        resetn_i <= 1'b1;
        wait_n(1);
        chk("output at reset", 8'h00, {7'h00, synth_out_o});
        for (int i = 0; i < 10; i++) begin
            rdc("reset value", offs[i], i == 5 ? 8'h01 : 8'h00);
        end
        wr(OFF_SUM_UPPER, 8'hFF);
        rdc("sum upper", OFF_SUM_UPPER, 8'h0F);
        wr(OFF_SUM_UPPER, 8'h00);
        wr(OFF_CLOCK, 8'hFF);
        rdc("clock config", OFF_CLOCK, 8'hEF);
        avs_byteenable_i <= 4'h0;
        wr(OFF_CLOCK, 8'h00);
        avs_byteenable_i <= 4'h1;
        rdc("masked write", OFF_CLOCK, 8'hEF);
        wr(OFF_IRQ, 8'h02);
        wr(OFF_CONTROL, 8'h11);
        rdc("control", OFF_CONTROL, 8'h31);
        chk("inverted idle", 8'h01, {7'h00, synth_out_o});
        rdc("flag on invert", OFF_IRQ, 8'h03);
        chk("irq while off", 8'h00, {7'h00, irq_o});
        wr(OFF_IRQ, 8'h02);
        rdc("flag cleared", OFF_IRQ, 8'h02);
        wr(OFF_IRQ, 8'h00);
        wr(OFF_CONTROL, 8'h00);
        rdc("no flag, irq off", OFF_IRQ, 8'h00);
        // toggle mode with the width field at its largest, which is ignored
        wr(OFF_STEP_UPPER, 8'h01);
        wr(OFF_STEP_LOW, 8'h00);
        wr(OFF_CLOCK, 8'hE0);
        wr(OFF_IRQ, 8'h02);
        wr(OFF_CONTROL, 8'h80);
        wait_n(150);
        chkw("toggle high", 16, high_len);
        chkw("toggle low", 16, low_len);
        rdc("overflow flag", OFF_IRQ, 8'h03);
        chk("irq request", 8'h01, {7'h00, irq_o});
        global_irq_enable_i <= 1'b0;
        wait_n(3);
        chk("irq no global", 8'h00, {7'h00, irq_o});
        global_irq_enable_i <= 1'b1;
        wr(OFF_CLOCK, 8'h01);
        wait_n(2);
        chk("fast osc kept", 8'h01, {7'h00, fast_osc_request_o});
        wr(OFF_CLOCK, 8'h00);
        wr(OFF_STEP_UPPER, 8'h02);
        wr(OFF_STEP_LOW, 8'h00);
        wait_n(100);
        chkw("reloaded step", 8, high_len);
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_IRQ, 8'h02);
        bus(1'b0, OFF_SUM_LOW, 8'h00);
        sv = q;
        w = synth_out_o;
        wait_n(40);
        rdc("held sum", OFF_SUM_LOW, sv);
        chk("held output", w[7:0], {7'h00, synth_out_o});
        rdc("no overflow", OFF_IRQ, 8'h02);
        wr(OFF_CLOCK, 8'h01);
        wait_n(2);
        chk("fast osc off", 8'h00, {7'h00, fast_osc_request_o});
        wr(OFF_STEP_UPPER, 8'h01);
        wr(OFF_STEP_LOW, 8'h00);
        // pulsed mode: widths stay below the 16-cycle overflow period
        for (w = 0; w < 4; w++) begin
            wr(OFF_CONTROL, 8'h00);
            wr(OFF_CLOCK, {w[2:0], 5'h00});
            wr(OFF_CONTROL, 8'h81);
            wait_n(100);
            chkw("pulse width", 1 << w, high_len);
            chkw("pulse gap", 16 - (1 << w), low_len);
        end
        wr(OFF_CONTROL, 8'h91);
        wait_n(100);
        chkw("inverted pulse", 8, low_len);
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_STEP_UPPER, 8'h04);
        wr(OFF_STEP_LOW, 8'h00);
        wr(OFF_CLOCK, 8'h02);
        slow_run <= 1'b1;
        wr(OFF_CONTROL, 8'h80);
        wait_n(300);
        chkw("slow source high", 32, high_len);
        chkw("slow source low", 32, low_len);
        wr(OFF_STEP_UPPER, 8'h02);
        wr(OFF_STEP_LOW, 8'h00);
        wait_n(400);
        chkw("slow reloaded step", 64, high_len);
        close_out();
    end
endmodule
